// [dpm_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module dpm_chk (
   // clock, reset, test reset
   input wire logic core_clk, nrst, trst,
   // observed ports
   input wire logic tckSync, tckRise, scanTdo, tdo, tdoOe, testClockReturn,
   input wire logic emulationPinZeroOut, emulationPinZeroOeN, cableActive,
   input wire logic breakEnable, attnReq, stepReq, instrDone, execEnable, halted,
   input wire dpm_pkg::dpm_evt_t debugEvt,
   input wire dpm_pkg::dpm_mode_t mode,
   input wire logic [dpm_pkg::DPM_CNT_W-1:0] cycleCount
);
   logic [2:0] upCnt_ff;
   wire logic emu = mode == dpm_pkg::DPM_MODE_NORM_EMU;
   always_ff @(posedge core_clk or negedge nrst)
      if (!nrst) upCnt_ff <= 3'h0;
      else if (upCnt_ff != 3'h7) upCnt_ff <= upCnt_ff + 3'h1;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst || upCnt_ff < 3'h4);
   sequence brkSeq; emu && breakEnable && !halted && (|debugEvt || attnReq); endsequence
   sequence stepSeq; emu && halted && stepReq; endsequence
   clk_ret_a: assert property (testClockReturn == $past(tckSync)) else $error("clock return lag");
   tdo_shift_a: assert property (tckRise |=> tdo == $past(scanTdo)) else $error("tdo shift");
   cable_mode_a: assert property (tdoOe == cableActive && cableActive == (emu || mode == dpm_pkg::DPM_MODE_WAITRST))
      else $error("cable state");
   emu_drive_a: assert property (emu [*2] |-> !emulationPinZeroOeN && emulationPinZeroOut == halted)
      else $error("emu pin drive");
   halt_freeze_a: assert property (halted |-> !execEnable ##1 $stable(cycleCount)) else $error("halt runs");
   count_run_a: assert property (execEnable |=> cycleCount == $past(cycleCount) + dpm_pkg::DPM_CNT_ONE)
      else $error("count step");
   break_halt_a: assert property (brkSeq |=> halted) else $error("no halt");
   no_halt_a: assert property ((!emu) [*2] |-> !halted) else $error("halt outside emu");
   step_go_a: assert property (stepSeq |=> execEnable && !halted) else $error("step start");
   step_end_a: assert property (stepSeq ##1 instrDone |=> halted) else $error("step end");
   mode_hold_a: assert property ((!trst) [*6] |-> $stable(mode)) else $error("mode moved");
endmodule // dpm_chk
bind dpm_debug_port dpm_chk dpm_chk_i (.core_clk, .nrst, .trst, .tckSync, .tckRise, .scanTdo, .tdo, .tdoOe,
   .testClockReturn, .emulationPinZeroOut, .emulationPinZeroOeN, .cableActive, .breakEnable, .attnReq,
   .stepReq, .instrDone, .execEnable, .halted, .debugEvt, .mode, .cycleCount);
`default_nettype wire

// [dpm_debug_port.sv]
`timescale 1ns/100ps
`default_nettype none
module dpm_debug_port (
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // jtag pins
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic trst,
   output logic tdo,
   output logic tdoOe,
   output logic testClockReturn,
   // emulation pins, enable low drives
   input wire logic emulationPinZeroIn,
   output logic emulationPinZeroOut,
   output logic emulationPinZeroOeN,
   input wire logic emulationPinOneIn,
   output logic emulationPinOneOut,
   output logic emulationPinOneOeN,
   // core side
   input wire dpm_pkg::dpm_evt_t debugEvt,
   input wire logic breakEnable,
   input wire logic attnReq,
   input wire logic runReq,
   input wire logic stepReq,
   input wire logic instrDone,
   input wire logic scanTdo,
   input wire logic releaseReset,
   output logic execEnable,
   output logic cpuDisable,
   output logic holdReset,
   output logic cableActive,
   output logic emuEnabled,
   output logic halted,
   output dpm_pkg::dpm_mode_t mode,
   output logic [dpm_pkg::DPM_CNT_W-1:0] cycleCount,
   output logic tckSync,
   output logic tmsSync,
   output logic tdiSync,
   output logic tckRise
);
   // ----------------------------------------
   // reset release
   // ----------------------------------------
   logic [1:0] rstSync_ff;
   logic rstN;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rstSync_ff <= dpm_pkg::DPM_SYNC_RST;
      end else begin
         rstSync_ff <= {rstSync_ff[0], 1'b1};
      end
   end
   assign rstN = rstSync_ff[1];

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   localparam int NSYN = 6;
   logic [NSYN-1:0] synA_ff;
   logic [NSYN-1:0] synB_ff;
   logic [NSYN-1:0] pinsRaw;
   assign pinsRaw = {tck, tms, tdi, trst, emulationPinOneIn, emulationPinZeroIn};
   // no reset: pins are settled when the power-up latch fires
   always_ff @(posedge core_clk) begin
      synA_ff <= pinsRaw;
      synB_ff <= synA_ff;
   end
   logic trstS, emu1S, emu0S;
   assign tckSync = synB_ff[5];
   assign tmsSync = synB_ff[4];
   assign tdiSync = synB_ff[3];
   assign trstS = synB_ff[2];
   assign emu1S = synB_ff[1];
   assign emu0S = synB_ff[0];

   // ----------------------------------------
   // edge detect
   // ----------------------------------------
   logic tckPrev_ff, trstPrev_ff, powerUp_ff;
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         tckPrev_ff <= 1'b0;
         trstPrev_ff <= 1'b0;
         powerUp_ff <= 1'b1;
      end else begin
         tckPrev_ff <= tckSync;
         trstPrev_ff <= trstS;
         powerUp_ff <= 1'b0;
      end
   end
   logic trstRise;
   assign tckRise = tckSync & ~tckPrev_ff;
   assign trstRise = trstS & ~trstPrev_ff;

   // ----------------------------------------
   // mode decode and latch
   // ----------------------------------------
   function automatic dpm_pkg::dpm_mode_t decodeMode(input logic t, input logic e1, input logic e0);
      if (t) begin
         decodeMode = dpm_pkg::DPM_MODE_NORM_EMU;
      end else begin
         unique case ({e1, e0})
            2'h0: decodeMode = dpm_pkg::DPM_MODE_PERIPH;
            2'h1: decodeMode = dpm_pkg::DPM_MODE_TEST;
            2'h2: decodeMode = dpm_pkg::DPM_MODE_WAITRST;
            2'h3: decodeMode = dpm_pkg::DPM_MODE_NORM;
         endcase
      end
   endfunction

   dpm_pkg::dpm_mode_t mode_ff, nxt_mode;
   logic latchNow;
   assign latchNow = powerUp_ff | trstRise;
   assign nxt_mode = latchNow ? decodeMode(trstS, emu1S, emu0S) : mode_ff;
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         mode_ff <= dpm_pkg::DPM_MODE_NORM;
      end else begin
         mode_ff <= nxt_mode;
      end
   end
   assign mode = mode_ff;

   // ----------------------------------------
   // wait-in-reset hold
   // ----------------------------------------
   logic waitHold_ff, nxt_waitHold;
   // set at the mode latch, cleared once by release; set wins
   assign nxt_waitHold = latchNow ? (nxt_mode == dpm_pkg::DPM_MODE_WAITRST) : (waitHold_ff & ~releaseReset);
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         waitHold_ff <= 1'b0;
      end else begin
         waitHold_ff <= nxt_waitHold;
      end
   end

   // ----------------------------------------
   // execution control
   // ----------------------------------------
   dpm_pkg::dpm_exec_t exec_ff, nxt_exec;
   logic breakEvt;
   assign emuEnabled = (mode_ff == dpm_pkg::DPM_MODE_NORM_EMU);
   assign breakEvt = emuEnabled & breakEnable & ((|debugEvt) | attnReq);
   always_comb begin
      nxt_exec = exec_ff;
      unique case (exec_ff)
         dpm_pkg::DPM_RUN: begin
            if (breakEvt) begin
               nxt_exec = dpm_pkg::DPM_HALT;
            end
         end
         dpm_pkg::DPM_HALT: begin
            if (stepReq) begin
               nxt_exec = dpm_pkg::DPM_STEP;
            end else if (runReq) begin
               nxt_exec = dpm_pkg::DPM_RUN;
            end
         end
         dpm_pkg::DPM_STEP: begin
            if (instrDone) begin
               nxt_exec = dpm_pkg::DPM_HALT;
            end
         end
         default: nxt_exec = dpm_pkg::DPM_HALT;
      endcase
      if (!emuEnabled) begin
         nxt_exec = dpm_pkg::DPM_RUN;
      end
   end
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         exec_ff <= dpm_pkg::DPM_RUN;
      end else begin
         exec_ff <= nxt_exec;
      end
   end
   assign halted = (exec_ff == dpm_pkg::DPM_HALT);

   // ----------------------------------------
   // core controls
   // ----------------------------------------
   logic periph;
   assign periph = (mode_ff == dpm_pkg::DPM_MODE_PERIPH) | (mode_ff == dpm_pkg::DPM_MODE_TEST);
   assign cpuDisable = periph;
   assign holdReset = waitHold_ff;
   assign cableActive = emuEnabled | (mode_ff == dpm_pkg::DPM_MODE_WAITRST);
   assign execEnable = ~halted & ~periph & ~waitHold_ff;

   // ----------------------------------------
   // cycle counter
   // ----------------------------------------
   logic [dpm_pkg::DPM_CNT_W-1:0] cnt_ff;
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         cnt_ff <= dpm_pkg::DPM_CNT_RST;
      end else if (execEnable) begin
         cnt_ff <= cnt_ff + dpm_pkg::DPM_CNT_ONE;
      end
   end
   assign cycleCount = cnt_ff;

   // ----------------------------------------
   // pin outputs
   // ----------------------------------------
   logic tdo_ff, tcr_ff;
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         tdo_ff <= 1'b0;
         tcr_ff <= 1'b0;
      end else begin
         tdo_ff <= tckRise ? scanTdo : tdo_ff;
         tcr_ff <= tckSync;
      end
   end
   assign tdo = tdo_ff;
   assign tdoOe = cableActive;
   assign testClockReturn = tcr_ff;
   assign emulationPinZeroOut = halted;
   assign emulationPinOneOut = halted;
   assign emulationPinZeroOeN = ~(emuEnabled & ~trstRise);
   assign emulationPinOneOeN = ~(emuEnabled & ~trstRise);
endmodule // dpm_debug_port
`default_nettype wire

// [dpm_debug_port_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module dpm_debug_port_tb_top;
   logic core_clk = 1'b0, nrst = 1'b0, trst = 1'b0, frame = 1'b0, e0v = 1'b1, e1v = 1'b1;
   logic breakEnable = 1'b0, attnReq = 1'b0, runReq = 1'b0, stepReq = 1'b0, instrDone = 1'b0;
   logic releaseReset = 1'b0, tck, tms, tdi, tdo, tdoOe, testClockReturn, e0Out, e0OeN, e1Out, e1OeN;
   logic execEnable, cpuDisable, holdReset, cableActive, emuEnabled, halted, tckSync, tmsS, tdiS;
   logic [dpm_pkg::DPM_CNT_W-1:0] cycleCount;
   dpm_pkg::dpm_evt_t debugEvt = '0;
   dpm_pkg::dpm_mode_t mode;
   int bad_count = 0, checked = 0;
   wire logic e0w = e0OeN ? e0v : e0Out;
   wire logic e1w = e1OeN ? e1v : e1Out;
   wire logic scanTdo = ~tdi;
   dpm_emu_model dpm_emu_model_i (.frame, .tck, .tms, .tdi);
   dpm_debug_port dpm_debug_port_i (.core_clk, .nrst, .tck, .tms, .tdi, .trst, .tdo, .tdoOe, .testClockReturn,
      .emulationPinZeroIn(e0w), .emulationPinZeroOut(e0Out), .emulationPinZeroOeN(e0OeN),
      .emulationPinOneIn(e1w), .emulationPinOneOut(e1Out), .emulationPinOneOeN(e1OeN),
      .debugEvt, .breakEnable, .attnReq, .runReq, .stepReq, .instrDone, .scanTdo, .releaseReset,
      .execEnable, .cpuDisable, .holdReset, .cableActive, .emuEnabled, .halted, .mode, .cycleCount,
      .tckSync, .tmsSync(tmsS), .tdiSync(tdiS), .tckRise());
   initial forever #5 core_clk = ~core_clk;
   task tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s exp %h got %h", nm, exp, got);
      end
   endtask
   task wrap_up;
      if (bad_count == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task powerup(input logic [2:0] pins, input dpm_pkg::dpm_mode_t m, input logic [2:0] outs);
      {trst, e1v, e0v} = pins;
      nrst = 1'b0;
      tick(12);
      nrst = 1'b1;
      tick(8);
      chk("mode", 32'(m), 32'(mode));
      chk("cpu hold cable", 32'(outs), 32'({cpuDisable, holdReset, cableActive}));
      {e1v, e0v} = 2'h3;
      tick(8);
      chk("mode held", 32'(m), 32'(mode));
   endtask
   task emu_on;
      frame = 1'b1;
      trst = 1'b1;
      tick(8);
      chk("emu mode", 32'(dpm_pkg::DPM_MODE_NORM_EMU), 32'(mode));
      chk("emu oe", 32'h3, 32'({emuEnabled, tdoOe}));
      trst = 1'b0;
      tick(48);
      chk("emu held", 32'(dpm_pkg::DPM_MODE_NORM_EMU), 32'(mode));
      frame = 1'b0;
      tick(20);
      chk("tck idle", 32'h0, 32'(tckSync));
      chk("sync idle", 32'({tms, tdi}), 32'({tmsS, tdiS}));
   endtask
   task breaks;
      logic [31:0] c;
      breakEnable = 1'b0;
      debugEvt = dpm_pkg::dpm_evt_t'(4'h2);
      tick(1);
      debugEvt = '0;
      chk("masked evt", 32'h0, 32'(halted));
      breakEnable = 1'b1;
      for (int i = 0; i < 4; i++) begin
         debugEvt = dpm_pkg::dpm_evt_t'(4'h1 << i);
         tick(1);
         debugEvt = '0;
         chk("evt halt", 32'h1, 32'(halted));
         c = cycleCount;
         tick(3);
         chk("count held", c, cycleCount);
         chk("emu pins", 32'h3, 32'({e1w, e0w}));
         runReq = 1'b1;
         tick(1);
         runReq = 1'b0;
         chk("run", 32'h0, 32'(halted));
      end
      attnReq = 1'b1;
      tick(1);
      attnReq = 1'b0;
      chk("attn halt", 32'h1, 32'(halted));
   endtask
   task step;
      logic [31:0] c;
      stepReq = 1'b1;
      tick(1);
      stepReq = 1'b0;
      chk("step exec", 32'h1, 32'({execEnable, halted} == 2'h2));
      c = cycleCount;
      tick(2);
      instrDone = 1'b1;
      tick(1);
      instrDone = 1'b0;
      chk("step halt", 32'h1, 32'(halted));
      chk("step count", c + 32'h3, cycleCount);
      stepReq = 1'b1;
      tick(1);
      stepReq = 1'b0;
      instrDone = 1'b1;
      tick(1);
      instrDone = 1'b0;
      chk("quick step", 32'h1, 32'(halted));
   endtask
   initial begin
      powerup(3'h0, dpm_pkg::DPM_MODE_PERIPH, 3'h4);
      powerup(3'h2, dpm_pkg::DPM_MODE_WAITRST, 3'h3);
      releaseReset = 1'b1;
      tick(2);
      chk("hold off", 32'h0, 32'(holdReset));
      releaseReset = 1'b0;
      tick(2);
      chk("hold stays off", 32'h0, 32'(holdReset));
      powerup(3'h3, dpm_pkg::DPM_MODE_NORM, 3'h0);
      breakEnable = 1'b1;
      debugEvt = dpm_pkg::dpm_evt_t'(4'h8);
      tick(1);
      debugEvt = '0;
      chk("no halt", 32'h0, 32'(halted));
      emu_on;
      breaks;
      step;
      wrap_up;
   end
   initial begin
      #100000;
      bad_count++;
      wrap_up;
   end
endmodule // dpm_debug_port_tb_top
`default_nettype wire

// [dpm_emu_model.sv]
`timescale 1ns/100ps
`default_nettype none
module dpm_emu_model (
   // frame control
   input wire logic frame,
   // jtag drive
   output logic tck,
   output logic tms,
   output logic tdi
);
   initial begin
      tck = 1'b0;
      tms = 1'b0;
      tdi = 1'b1;
   end
   // tck stands low outside frames
   always #62.5 tck = frame ? ~tck : 1'b0;
   always @(negedge tck) begin
      tms <= ~tms;
      tdi <= tdi ^ tms;
   end
endmodule // dpm_emu_model
`default_nettype wire

// [dpm_pkg.sv]
package dpm_pkg;
   // ----------------------------------------
   // operating modes
   // ----------------------------------------
   typedef enum logic [2:0] {
      DPM_MODE_PERIPH = 3'h0,
      DPM_MODE_TEST = 3'h1,
      DPM_MODE_WAITRST = 3'h2,
      DPM_MODE_NORM = 3'h3,
      DPM_MODE_NORM_EMU = 3'h4
   } dpm_mode_t;

   // ----------------------------------------
   // execution states
   // ----------------------------------------
   typedef enum logic [1:0] {
      DPM_RUN = 2'h0,
      DPM_HALT = 2'h1,
      DPM_STEP = 2'h2
   } dpm_exec_t;

   // ----------------------------------------
   // debug event sources
   // ----------------------------------------
   typedef struct packed {
      logic swBreak;
      logic hwBreak;
      logic extTrig;
      logic hostReq;
   } dpm_evt_t;

   localparam int DPM_CNT_W = 32;
   localparam logic [DPM_CNT_W-1:0] DPM_CNT_RST = 32'h0000_0000;
   localparam logic [DPM_CNT_W-1:0] DPM_CNT_ONE = 32'h0000_0001;
   localparam logic [1:0] DPM_SYNC_RST = 2'h0;
endpackage : dpm_pkg
